// ---- rtl/mws_pkg.sv ----
// Functional notes
// RULE1: wave table holds 64 entries, addresses 0 to 63, one quarter period.
// RULE2: full-period index runs 0 to 255; table address derives from it.
// RULE3: resolution code 6..0 selects step 1,2,4,8,16,32,64.
// RULE4: positive step adds step size, negative subtracts, wrapping mod 256.
// RULE5: sine magnitude drives phase A, cosine magnitude drives phase B.
// RULE6: sign bits per quadrant: 11, 10, 00, 01 for A,B.
// RULE7: fast decay A,B: 01 in quadrants 1,3; 10 in quadrants 2,4.
// RULE8: polarity inputs invert sign bits and fast decay bits.
// RULE9: sine ascends in odd quadrants, descends in even; cosine opposite.
// RULE10: mirrored address one past table end outputs entry 63 as peak.
// RULE11: index cleared only by power-on reset, not by resolution change.
// RULE12: host accounts for index offset after resolution changes.
// RULE13: host should load every table entry.
// RULE14: partial table needs one fixed resolution since power-on reset.
// RULE15: narrower driver takes the magnitude MSBs.
// RULE16: table storage is not initialized by reset.
// RULE17: each table write carries two successive 6-bit entries; 32 fill it.
// RULE18: each axis has own index and resolution; table shared.
package mws_pkg;
  // ----------------------------------------------------------------
  // widths and table shape
  // ----------------------------------------------------------------
  localparam int MWS_IDX_W = 8;
  localparam int MWS_ADDR_W = 6;
  localparam int MWS_VAL_W = 6;
  localparam int MWS_RES_W = 3;
  localparam int MWS_PAIR_W = 5;
  localparam logic [MWS_ADDR_W-1:0] MWS_PEAK_ADDR = 6'h3f;
  localparam logic [MWS_IDX_W-1:0] MWS_IDX_RST = 8'h00;
  localparam logic [MWS_RES_W-1:0] MWS_RES_RST = 3'h6;
  localparam logic [MWS_RES_W-1:0] MWS_RES_FINEST = 3'h6;
  // ----------------------------------------------------------------
  // quadrant codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MWS_Q1 = 2'b00,
    MWS_Q2 = 2'b01,
    MWS_Q3 = 2'b10,
    MWS_Q4 = 2'b11
  } mws_quad_t;
endpackage : mws_pkg

// ---- rtl/mws_lut_if.sv ----
`timescale 1ns/1ps
interface mws_lut_if;
  import mws_pkg::*;
  logic [MWS_ADDR_W-1:0] sin_addr;
  logic [MWS_ADDR_W-1:0] cos_addr;
  logic [MWS_VAL_W-1:0] sin_val;
  logic [MWS_VAL_W-1:0] cos_val;
  modport seq (output sin_addr, output cos_addr,
               input sin_val, input cos_val);
  modport mem (input sin_addr, input cos_addr,
               output sin_val, output cos_val);
endinterface : mws_lut_if

// ---- rtl/mws_lut.sv ----
`timescale 1ns/1ps
module mws_lut
  import mws_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [MWS_PAIR_W-1:0] wr_pair,
  input wire logic [MWS_VAL_W-1:0] wr_even,
  input wire logic [MWS_VAL_W-1:0] wr_odd,
  mws_lut_if.mem rd
);
  // no reset on purpose: contents undefined until loaded [RULE16]
  logic [MWS_VAL_W-1:0] mem_q [0:(1<<MWS_ADDR_W)-1]; // [RULE1]

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[{wr_pair, 1'b0}] <= wr_even; // [RULE17]
      mem_q[{wr_pair, 1'b1}] <= wr_odd; // [RULE17]
    end
  end

  // shared read ports serve every axis [RULE18]
  assign rd.sin_val = mem_q[rd.sin_addr];
  assign rd.cos_val = mem_q[rd.cos_addr];
endmodule : mws_lut

// ---- rtl/mws_sequencer.sv ----
`timescale 1ns/1ps
module mws_sequencer
  import mws_pkg::*;
#(
  parameter int AXES = 3
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lut_wr_en,
  input wire logic [MWS_PAIR_W-1:0] lut_wr_pair,
  input wire logic [MWS_VAL_W-1:0] lut_wr_even,
  input wire logic [MWS_VAL_W-1:0] lut_wr_odd,
  input wire logic [AXES-1:0] step,
  input wire logic [AXES-1:0] dir_pos,
  input wire logic [AXES*MWS_RES_W-1:0] res_sel,
  input wire logic [AXES-1:0] pol_sign,
  input wire logic [AXES-1:0] pol_decay,
  input wire logic [AXES-1:0] sel_axis_onehot,
  output logic [AXES*MWS_IDX_W-1:0] wave_index,
  output logic [MWS_VAL_W-1:0] phase_a_mag,
  output logic [MWS_VAL_W-1:0] phase_b_mag,
  output logic phase_a_sign,
  output logic phase_b_sign,
  output logic phase_a_fast_decay,
  output logic phase_b_fast_decay
);
  // ----------------------------------------------------------------
  // per-axis wave index
  // ----------------------------------------------------------------
  logic [MWS_IDX_W-1:0] idx_q [AXES];

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis // [RULE18]
      logic [MWS_RES_W-1:0] res;
      logic [MWS_IDX_W-1:0] inc;
      assign res = res_sel[g*MWS_RES_W +: MWS_RES_W];
      // codes above 6 are undefined; treat as finest step
      assign inc = (res > MWS_RES_FINEST) ? 8'h01 :
                   8'(8'h01 << (MWS_RES_FINEST - res)); // [RULE3]
      // resolution changes leave the index alone [RULE11]
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          idx_q[g] <= MWS_IDX_RST; // [RULE11]
        end else if (step[g]) begin
          if (dir_pos[g]) begin
            idx_q[g] <= MWS_IDX_W'(idx_q[g] + inc); // [RULE4]
          end else begin
            idx_q[g] <= MWS_IDX_W'(idx_q[g] - inc); // [RULE4]
          end
        end
      end
      assign wave_index[g*MWS_IDX_W +: MWS_IDX_W] = idx_q[g]; // [RULE2]
    end
  endgenerate

  // ----------------------------------------------------------------
  // axis select for the driver chain
  // ----------------------------------------------------------------
  logic [MWS_IDX_W-1:0] sel_idx;
  logic sel_pol_s;
  logic sel_pol_d;
  always_comb begin
    sel_idx = '0;
    sel_pol_s = 1'b0;
    sel_pol_d = 1'b0;
    for (int i = 0; i < AXES; i++) begin
      if (sel_axis_onehot[i]) begin
        sel_idx = idx_q[i];
        sel_pol_s = pol_sign[i];
        sel_pol_d = pol_decay[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // quadrant mirroring
  // ----------------------------------------------------------------
  mws_quad_t quad;
  logic [MWS_ADDR_W-1:0] pos;
  logic [MWS_ADDR_W:0] mirror;
  logic desc_sin;
  logic peak_sin;
  logic peak_cos;
  assign quad = mws_quad_t'(sel_idx[7:6]); // [RULE2]
  assign pos = sel_idx[5:0];
  assign mirror = 7'h40 - {1'b0, pos};
  assign desc_sin = sel_idx[6]; // [RULE9]
  // 64 - pos overflows at pos 0: hold peak instead [RULE10]
  assign peak_sin = desc_sin && (pos == 6'h00); // [RULE10]
  assign peak_cos = !desc_sin && (pos == 6'h00); // [RULE10]

  mws_lut_if lut_bus ();
  assign lut_bus.sin_addr = peak_sin ? MWS_PEAK_ADDR :
                            (desc_sin ? mirror[5:0] : pos); // [RULE9]
  assign lut_bus.cos_addr = peak_cos ? MWS_PEAK_ADDR :
                            (desc_sin ? pos : mirror[5:0]); // [RULE9]

  mws_lut u_lut (
    .clk(clk),
    .wr_en(lut_wr_en),
    .wr_pair(lut_wr_pair),
    .wr_even(lut_wr_even),
    .wr_odd(lut_wr_odd),
    .rd(lut_bus.mem)
  );

  // ----------------------------------------------------------------
  // sign and decay bits
  // ----------------------------------------------------------------
  logic sa_d, sb_d, fa_d, fb_d;
  always_comb begin
    unique case (quad)
      MWS_Q1: begin sa_d = 1'b1; sb_d = 1'b1; end // [RULE6]
      MWS_Q2: begin sa_d = 1'b1; sb_d = 1'b0; end // [RULE6]
      MWS_Q3: begin sa_d = 1'b0; sb_d = 1'b0; end // [RULE6]
      MWS_Q4: begin sa_d = 1'b0; sb_d = 1'b1; end // [RULE6]
    endcase
    fa_d = quad[0]; // [RULE7]
    fb_d = !quad[0]; // [RULE7]
  end

  // registered outputs, one cycle after index or select changes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_a_mag <= '0;
      phase_b_mag <= '0;
    end else begin
      phase_a_mag <= lut_bus.sin_val; // [RULE5]
      phase_b_mag <= lut_bus.cos_val; // [RULE5]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_a_sign <= 1'b0;
      phase_b_sign <= 1'b0;
      phase_a_fast_decay <= 1'b0;
      phase_b_fast_decay <= 1'b0;
    end else begin
      phase_a_sign <= sa_d ^ sel_pol_s; // [RULE8]
      phase_b_sign <= sb_d ^ sel_pol_s; // [RULE8]
      phase_a_fast_decay <= fa_d ^ sel_pol_d; // [RULE8]
      phase_b_fast_decay <= fb_d ^ sel_pol_d; // [RULE8]
    end
  end
endmodule : mws_sequencer

// ---- bench/mws_seq_props.sv ----
`timescale 1ns/1ps
module mws_seq_props
  import mws_pkg::*;
#(
  parameter int AXES = 3
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [AXES-1:0] step,
  input wire logic [AXES-1:0] dir_pos,
  input wire logic [AXES*MWS_RES_W-1:0] res_sel,
  input wire logic [AXES-1:0] pol_sign,
  input wire logic [AXES-1:0] pol_decay,
  input wire logic [AXES-1:0] sel_axis_onehot,
  input wire logic [AXES*MWS_IDX_W-1:0] wave_index,
  input wire logic [MWS_VAL_W-1:0] phase_a_mag,
  input wire logic [MWS_VAL_W-1:0] phase_b_mag,
  input wire logic phase_a_sign,
  input wire logic phase_b_sign,
  input wire logic phase_a_fast_decay,
  input wire logic phase_b_fast_decay
);
  logic [7:0] inc0;
  logic [7:0] nxt0;
  logic [3:0] bits0;
  logic sel0;
  // code 7 behaves as the finest step
  assign inc0 = (res_sel[2:0] == 3'h7) ? 8'h01 :
                8'h01 << (3'h6 - res_sel[2:0]);
  assign nxt0 = dir_pos[0] ? 8'(wave_index[7:0] + inc0) :
                8'(wave_index[7:0] - inc0);
  assign sel0 = (sel_axis_onehot == AXES'(1));
  assign bits0 = {~wave_index[7] ^ pol_sign[0],
                  ~^wave_index[7:6] ^ pol_sign[0],
                  wave_index[6] ^ pol_decay[0],
                  ~wave_index[6] ^ pol_decay[0]};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_fs_up;
    sel0 && wave_index[7:0] == 8'h00 && step[0] && dir_pos[0] &&
      res_sel[2:0] == 3'h0;
  endsequence
  property p_step;
    step[0] |=> wave_index[7:0] == $past(nxt0);
  endproperty
  property p_hold;
    !step[0] |=> $stable(wave_index[7:0]);
  endproperty
  property p_hold1;
    !step[1] |=> $stable(wave_index[15:8]);
  endproperty
  property p_sign;
    sel0 |=> {phase_a_sign, phase_b_sign} == $past(bits0[3:2]);
  endproperty
  property p_decay;
    sel0 |=> phase_a_fast_decay == $past(bits0[1]) &&
      phase_b_fast_decay == $past(bits0[0]);
  endproperty
  property p_mid;
    sel0 && wave_index[5:0] == 6'h20 |=> phase_a_mag == phase_b_mag;
  endproperty
  property p_peak;
    s_fs_up ##1 sel0 |=> phase_a_mag == $past(phase_b_mag);
  endproperty
  property p_dec;
    step[0] && !dir_pos[0] && wave_index[7:0] < inc0 |=>
      wave_index[7:0] > $past(wave_index[7:0]);
  endproperty
  a_step: assert property (p_step)
    else $error("axis 0 index step wrong");
  a_hold: assert property (p_hold)
    else $error("axis 0 index moved");
  a_hold1: assert property (p_hold1)
    else $error("axis 1 index moved");
  a_sign: assert property (p_sign)
    else $error("sign bits wrong");
  a_decay: assert property (p_decay)
    else $error("decay bits wrong");
  a_mid: assert property (p_mid)
    else $error("mid magnitudes differ");
  a_peak: assert property (p_peak)
    else $error("peak entry wrong");
  a_dec: assert property (p_dec)
    else $error("no wrap downward");
endmodule : mws_seq_props

bind mws_sequencer mws_seq_props #(.AXES(AXES)) u_props (
  .clk(clk),
  .sys_rst(sys_rst),
  .step(step),
  .dir_pos(dir_pos),
  .res_sel(res_sel),
  .pol_sign(pol_sign),
  .pol_decay(pol_decay),
  .sel_axis_onehot(sel_axis_onehot),
  .wave_index(wave_index),
  .phase_a_mag(phase_a_mag),
  .phase_b_mag(phase_b_mag),
  .phase_a_sign(phase_a_sign),
  .phase_b_sign(phase_b_sign),
  .phase_a_fast_decay(phase_a_fast_decay),
  .phase_b_fast_decay(phase_b_fast_decay)
);

// ---- bench/mws_drv_model.sv ----
`timescale 1ns/1ps
module mws_drv_model
  import mws_pkg::*;
(
  input wire logic [MWS_VAL_W-1:0] phase_a_mag,
  input wire logic [MWS_VAL_W-1:0] phase_b_mag,
  output logic [3:0] dac_a,
  output logic [3:0] dac_b
);
  // four-bit driver, low bits dropped
  assign dac_a = phase_a_mag[5:2];
  assign dac_b = phase_b_mag[5:2];
endmodule : mws_drv_model

// ---- bench/microstep_wave_sequencer_bench.sv ----
`timescale 1ns/1ps
module microstep_wave_sequencer_bench;
  import mws_pkg::*;
  logic clk = 0, sys_rst = 1, lut_wr_en = 0, sa, sb, fa, fb;
  logic [4:0] lut_wr_pair = '0;
  logic [5:0] lut_wr_even = '0, lut_wr_odd = '0, amag, bmag;
  logic [2:0] step = '0, dir_pos = '0, pol_sign = '0, pol_decay = '0;
  logic [2:0] sel_axis_onehot = 3'b001;
  logic [8:0] res_sel = '0;
  logic [23:0] wave_index;
  logic [3:0] dac_a, dac_b;
  logic [7:0] e [3] = '{8'h00, 8'h00, 8'h00};
  int fail_count = 0, cmp_count = 0;
  int vs = 0;
  always #2.5 clk = ~clk;
  mws_sequencer #(.AXES(3)) DUT (.clk(clk), .sys_rst(sys_rst),
    .lut_wr_en(lut_wr_en), .lut_wr_pair(lut_wr_pair), .lut_wr_even(lut_wr_even),
    .lut_wr_odd(lut_wr_odd), .step(step), .dir_pos(dir_pos),
    .res_sel(res_sel), .pol_sign(pol_sign), .pol_decay(pol_decay),
    .sel_axis_onehot(sel_axis_onehot),
    .wave_index(wave_index), .phase_a_mag(amag), .phase_b_mag(bmag),
    .phase_a_sign(sa), .phase_b_sign(sb), .phase_a_fast_decay(fa),
    .phase_b_fast_decay(fb));
  mws_drv_model drv (.phase_a_mag(amag), .phase_b_mag(bmag),
    .dac_a(dac_a), .dac_b(dac_b));
  task results;
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input logic [23:0] s, input logic [23:0] x);
    cmp_count++;
    if (s !== x) begin
      fail_count++;
      $display("Error at %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // table entry i holds i ^ 2a so mirrored reads are told apart
  function automatic logic [15:0] ph(input logic [7:0] i, input logic ps,
                                     input logic pd);
    logic [5:0] p, m;
    p = i[5:0];
    m = (p == 6'h00) ? 6'h3f : 6'h00 - p;
    return {(i[6] ? m : p) ^ 6'h2a, (i[6] ? p : m) ^ 6'h2a,
            ~i[7] ^ ps, ~^i[7:6] ^ ps, i[6] ^ pd, ~i[6] ^ pd};
  endfunction : ph
  // vs names the axis that the select inputs put on the phase outputs
  task mv(input int ax, input logic d, input logic [2:0] r);
    logic [7:0] inc;
    logic [15:0] x;
    inc = (r == 3'h7) ? 8'h01 : 8'h01 << (3'h6 - r);
    step[ax] = 1;
    dir_pos[ax] = d;
    res_sel[3*ax +: 3] = r;
    e[ax] = d ? e[ax] + inc : e[ax] - inc;
    @(negedge clk) step[ax] = 0;
    chk(wave_index, {e[2], e[1], e[0]});
    @(negedge clk);
    x = ph(e[vs], pol_sign[vs], pol_decay[vs]);
    chk({amag, bmag, sa, sb, fa, fb}, x);
    chk({dac_a, dac_b}, {x[15:12], x[9:6]});
  endtask : mv
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 0;
    chk(wave_index, 24'h0000_0000);
    for (int n = 0; n < 32; n++) begin
      lut_wr_en = 1;
      lut_wr_pair = n[4:0];
      lut_wr_even = 6'(2 * n) ^ 6'h2a;
      lut_wr_odd = 6'(2 * n + 1) ^ 6'h2a;
      @(negedge clk);
    end
    lut_wr_en = 0;
    for (int r = 0; r < 8; r++) mv(0, 1, 3'(r));
    for (int k = 0; k < 12; k++) begin
      pol_sign[0] = k[0];
      pol_decay[0] = k[1];
      mv(k % 2, 0, 3'(k % 3));
    end
    // two select bits set: the higher axis must win the view
    sel_axis_onehot = 3'b011;
    vs = 1;
    pol_sign[1] = 1;
    pol_decay[1] = 1;
    for (int k = 0; k < 4; k++) begin
      mv(1, 1, 3'(k + 1));
    end
    results();
  end
  initial begin
    #2000;
    fail_count++;
    results();
  end
endmodule : microstep_wave_sequencer_bench
